// ==== rtl/serdes_ber_ctrl.sv ====
// lane bit-error checkers and receive phy control behind an axi4-lite slave
`timescale 1ns/100ps
module serdes_ber_ctrl #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // recovered serial bits, one per connected lane
    input wire logic [serdes_ber_pkg::CONNECTED_LANES-1:0] lane_rx_bit,
    input wire logic [serdes_ber_pkg::CONNECTED_LANES-1:0] lane_rx_valid,
    // phy control
    output logic [2:0] recovery_loop_setting,
    output logic offset_cal_enable,
    output logic signal_loss_detect_enable,
    output logic bit_error_test_enable,
    // interrupt
    output logic irq
);
    import serdes_ber_pkg::*;

    // overview
    // register word map, byte address = index * 4, payload in bits 7..0:
    //   test control   index 1a0  bit 0 arms the lane checkers
    //   lane tallies   index 1b0 + physical lane, sixteen slots
    //   phy control    index 1c1  loop setting, offset cal, signal loss detect
    //   irq status     index 1f0  sticky, write one to clear
    //   irq mask       index 1f1  same layout as status
    // only address bits 11..2 are decoded, so aliases above bit 11 fold back
    // byte lane 0 strobe gates every write; other strobes are ignored
    //
    // write timing:
    //   address and data may arrive in either order and are parked separately
    //   the cycle after both are parked the register updates and bvalid rises
    //   nothing new is accepted until the response has been taken
    //   unmapped indices answer slverr and change nothing
    //   tally slots accept writes and drop them, so a probe never faults
    //   awprot and arprot are accepted and ignored
    //
    // read timing:
    //   the answer is registered one cycle after the address is taken
    //   arready stays low while an answer is waiting, so one read is in flight
    //   unmapped indices answer slverr with zero data
    //   rdata holds until rready, so a slow master sees a stable word
    //
    // lane checkers:
    //   lane index 0 of the rx ports is physical lane 6, index 1 is lane 14
    //   each connected lane keeps a seven bit history of received bits
    //   the first seven valid bits after arming only fill the history
    //   every later valid bit is compared with the prbs7 prediction
    //   a cycle with lane valid low shifts nothing and compares nothing
    //   a bit error in the line also poisons up to two later predictions;
    //   this is accepted, since a single flip then counts a few times
    //   and the tally is an error indicator, not an exact bit count
    //   the tally stops at 255 so a long run cannot fold back to small values
    //   the tally is readable the cycle after the bit that changed it
    //   disarming clears the tallies and drops the lock on every lane
    //   re-arming restarts from empty histories one cycle after the rise
    //
    // interrupts:
    //   status bit per lane for any error, and per lane for reaching the ceiling
    //   status bits are only set while the checkers are armed
    //   an event in the same cycle as its clear wins, so no event is lost
    //   irq is a level, high while any unmasked status bit is set
    //   mask reset is zero, so irq stays low until software opts in
    //
    // phy control:
    //   the fields drive the receiver straight from the register
    //   loop settings 0..3 are second order, 4..7 first order, 4 is default
    //   writes while the link runs are taken, but may upset a locked receiver
    //
    // reset:
    //   synchronous and active low; all readies are high once it is released
    //   phy control returns to loop setting 4 with both detectors enabled
    //   the checkers restart disarmed with zero tallies
    //
    // limitations:
    //   only the prbs7 polynomial is checked; other patterns count as errors
    //   pattern selection and link enable live outside this block
    //   tallies of lanes that are not connected read zero, not live values
    //   reserved control bits are stored and read back but steer nothing

    // ---------------- register storage ----------------
    logic [7:0] test_ctrl_reg;
    logic [7:0] test_ctrl_next;
    logic [7:0] phy_ctrl_reg;
    logic [7:0] phy_ctrl_next;
    logic [IRQ_BITS-1:0] irq_status_reg;
    logic [IRQ_BITS-1:0] irq_status_next;
    logic [IRQ_BITS-1:0] irq_mask_reg;
    logic [IRQ_BITS-1:0] irq_mask_next;
    logic enable_prev_reg;

    // ---------------- write channel state ----------------
    logic aw_held_reg;
    logic w_held_reg;
    logic [9:0] w_index_reg;
    logic [7:0] w_byte_reg;
    logic w_lane0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    // ---------------- read channel state ----------------
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ---------------- lane state, packed for the read mux ----------------
    logic [CONNECTED_LANES-1:0][7:0] tally_w;
    logic [CONNECTED_LANES-1:0] err_event_w;
    logic [CONNECTED_LANES-1:0] sat_event_w;

    // ---------------- write path ----------------
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire write_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_test_ctrl = write_fire && w_lane0_reg && (w_index_reg == IDX_ERROR_TEST_CONTROL);
    wire wr_phy_ctrl = write_fire && w_lane0_reg && (w_index_reg == IDX_SERDES_PHY_CONTROL);
    wire wr_irq_status = write_fire && w_lane0_reg && (w_index_reg == IDX_IRQ_STATUS);
    wire wr_irq_mask = write_fire && w_lane0_reg && (w_index_reg == IDX_IRQ_MASK);
    // tally bytes are read-only: writes there are accepted and dropped
    wire w_is_tally = (w_index_reg[9:LANE_SLOT_BITS] == IDX_LANE_ERROR_TALLY[9:LANE_SLOT_BITS]);
    wire w_mapped = (w_index_reg == IDX_ERROR_TEST_CONTROL)
        || (w_index_reg == IDX_SERDES_PHY_CONTROL)
        || (w_index_reg == IDX_IRQ_STATUS)
        || (w_index_reg == IDX_IRQ_MASK)
        || w_is_tally;

    // one write outstanding: address and data stay parked until the write fires, and bvalid blocks new ones until the response is taken
    assign awready = !aw_held_reg && !bvalid_reg;
    assign wready = !w_held_reg && !bvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // reserved test control bits 7..1 and phy control bits 7, 3..2 are plain storage and steer nothing
    assign test_ctrl_next = wr_test_ctrl ? w_byte_reg : test_ctrl_reg;
    assign phy_ctrl_next = wr_phy_ctrl ? w_byte_reg : phy_ctrl_reg;
    assign irq_mask_next = wr_irq_mask ? w_byte_reg[IRQ_BITS-1:0] : irq_mask_reg;

    // write-one-to-clear; an event in the clearing cycle still sets its bit
    wire [IRQ_BITS-1:0] irq_clear = wr_irq_status ? w_byte_reg[IRQ_BITS-1:0] : '0;
    wire [IRQ_BITS-1:0] irq_events = {sat_event_w, err_event_w};
    assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            w_index_reg <= 10'h000;
            w_byte_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                w_index_reg <= awaddr[11:2];
            end else if (write_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_byte_reg <= wdata[7:0];
                w_lane0_reg <= wstrb[0];
            end else if (write_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (write_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= w_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_ctrl_reg <= RST_ERROR_TEST_CONTROL;
            phy_ctrl_reg <= RST_SERDES_PHY_CONTROL;
            irq_status_reg <= '0;
            irq_mask_reg <= RST_IRQ_MASK;
            enable_prev_reg <= 1'b0;
        end else begin
            test_ctrl_reg <= test_ctrl_next;
            // software should only change this while the link is disabled; not enforced
            phy_ctrl_reg <= phy_ctrl_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            enable_prev_reg <= test_ctrl_reg[TEST_ENABLE_BIT];
        end
    end

    // ---------------- control outputs ----------------
    wire test_enable = test_ctrl_reg[TEST_ENABLE_BIT];
    wire enable_rise = test_enable && !enable_prev_reg;

    assign bit_error_test_enable = test_enable;
    assign recovery_loop_setting = phy_ctrl_reg[LOOP_SETTING_MSB:LOOP_SETTING_LSB];
    assign offset_cal_enable = phy_ctrl_reg[OFFSET_CAL_BIT];
    assign signal_loss_detect_enable = phy_ctrl_reg[SIGNAL_LOSS_BIT];
    wire [IRQ_BITS-1:0] irq_pending = irq_status_reg & irq_mask_reg;
    assign irq = |irq_pending;

    // ---------------- per-lane self-synchronising checkers ----------------
    genvar g;
    generate
        for (g = 0; g < CONNECTED_LANES; g++) begin : g_lane
            logic [PRBS_LEN-1:0] hist_reg;
            logic [2:0] fill_reg;
            logic [7:0] tally_reg;
            // the history is filled from the line itself, so no seed is needed
            wire locked = (fill_reg == PRBS_FILL_DONE);
            wire predicted = hist_reg[PRBS_TAP_A] ^ hist_reg[PRBS_TAP_B];
            wire mismatch = locked && lane_rx_valid[g] && (lane_rx_bit[g] != predicted);
            wire at_max = (tally_reg == TALLY_MAX);
            wire counting = test_enable && !enable_rise;

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    hist_reg <= '0;
                    fill_reg <= 3'h0;
                    tally_reg <= 8'h00;
                end else if (!test_enable) begin
                    // idle: nothing is counted and the lock is dropped
                    fill_reg <= 3'h0;
                    tally_reg <= 8'h00;
                end else if (enable_rise) begin
                    fill_reg <= 3'h0;
                    tally_reg <= 8'h00;
                end else if (lane_rx_valid[g]) begin
                    hist_reg <= {hist_reg[PRBS_LEN-2:0], lane_rx_bit[g]};
                    if (!locked) begin
                        fill_reg <= fill_reg + 3'h1;
                    end
                    if (mismatch && !at_max) begin
                        tally_reg <= tally_reg + 8'h01;
                    end
                end
            end

            assign tally_w[g] = tally_reg;
            assign err_event_w[g] = counting && mismatch;
            // flags the error that pushes the count onto its ceiling
            assign sat_event_w[g] = counting && mismatch && (tally_reg == TALLY_MAX - 8'h01);
        end
    endgenerate

    // ---------------- read path ----------------
    wire ar_take = arvalid && arready;
    wire [9:0] r_index = araddr[11:2];
    wire r_is_tally = (r_index[9:LANE_SLOT_BITS] == IDX_LANE_ERROR_TALLY[9:LANE_SLOT_BITS]);
    wire [LANE_SLOT_BITS-1:0] r_slot = r_index[LANE_SLOT_BITS-1:0];
    wire r_hit_test = (r_index == IDX_ERROR_TEST_CONTROL);
    wire r_hit_phy = (r_index == IDX_SERDES_PHY_CONTROL);
    wire r_hit_status = (r_index == IDX_IRQ_STATUS);
    wire r_hit_mask = (r_index == IDX_IRQ_MASK);
    logic [7:0] tally_sel;
    logic [7:0] read_byte;
    logic read_hit;

    // disconnected slots have no receiver and read as zero
    always_comb begin
        tally_sel = 8'h00;
        for (int k = 0; k < CONNECTED_LANES; k++) begin
            if (r_slot == LANE_PHYS[k]) begin
                tally_sel = tally_w[k];
            end
        end
    end

    always_comb begin
        read_byte = 8'h00;
        read_hit = 1'b1;
        if (r_hit_test) begin
            read_byte = test_ctrl_reg;
        end else if (r_hit_phy) begin
            read_byte = phy_ctrl_reg;
        end else if (r_hit_status) begin
            read_byte = {{(8-IRQ_BITS){1'b0}}, irq_status_reg};
        end else if (r_hit_mask) begin
            read_byte = {{(8-IRQ_BITS){1'b0}}, irq_mask_reg};
        end else if (r_is_tally) begin
            read_byte = tally_sel;
        end else begin
            read_hit = 1'b0;
        end
    end

    assign arready = !rvalid_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, read_byte};
            rresp_reg <= read_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule

// ==== include/serdes_ber_pkg.sv ====
// constants and register map for the lane bit-error test and phy control block
package serdes_ber_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_ERROR_TEST_CONTROL = 10'h1a0;
    localparam logic [9:0] IDX_LANE_ERROR_TALLY = 10'h1b0;
    localparam logic [9:0] IDX_SERDES_PHY_CONTROL = 10'h1c1;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h1f0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h1f1;
    localparam int LANE_SLOTS = 16;
    localparam int LANE_SLOT_BITS = 4;

    // reset values
    localparam logic [7:0] RST_ERROR_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_SERDES_PHY_CONTROL = 8'h43;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    // field positions
    localparam int TEST_ENABLE_BIT = 0;
    localparam int LOOP_SETTING_LSB = 4;
    localparam int LOOP_SETTING_MSB = 6;
    localparam int OFFSET_CAL_BIT = 1;
    localparam int SIGNAL_LOSS_BIT = 0;

    // interrupt status layout: [1:0] error seen per lane, [3:2] saturated per lane
    localparam int IRQ_BITS = 4;
    localparam int IRQ_ERR_LSB = 0;
    localparam int IRQ_SAT_LSB = 2;

    // connected physical lanes
    localparam int CONNECTED_LANES = 2;
    localparam logic [3:0] LANE_PHYS [CONNECTED_LANES] = '{4'h6, 4'he};

    // prbs7 checker, x^7 + x^6 + 1
    localparam int PRBS_LEN = 7;
    localparam int PRBS_TAP_A = 6;
    localparam int PRBS_TAP_B = 5;
    localparam logic [2:0] PRBS_FILL_DONE = 3'h7;
    localparam logic [7:0] TALLY_MAX = 8'hff;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verif/prbs_tx_model.sv ====
// far-end serial transmitter model sending a prbs7 stream on each lane
`timescale 1ns/100ps
module prbs_tx_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // stream control per lane
    input wire logic [1:0] run,
    input wire logic [1:0] slow,
    input wire logic [1:0] flip,
    // serial bits towards the receiver
    output logic [1:0] tx_bit,
    output logic [1:0] tx_valid
);
    logic [6:0] lfsr_reg [2];
    logic phase_reg;
    always_ff @(posedge clk) begin
        phase_reg <= rst_n && !phase_reg;
        for (int g = 0; g < 2; g++) begin
            if (!rst_n) begin
                lfsr_reg[g] <= 7'h01 + 7'(g);
                tx_valid[g] <= 1'b0;
                tx_bit[g] <= 1'b0;
            end else if (run[g] && (!slow[g] || phase_reg)) begin
                lfsr_reg[g] <= {lfsr_reg[g][5:0], lfsr_reg[g][6] ^ lfsr_reg[g][5]};
                tx_bit[g] <= lfsr_reg[g][6] ^ lfsr_reg[g][5] ^ flip[g];
                tx_valid[g] <= 1'b1;
            end else begin
                // no bit on the line: toggle so a stale bit can never pass for data
                tx_bit[g] <= !tx_bit[g];
                tx_valid[g] <= 1'b0;
            end
        end
    end
endmodule

// ==== verif/serdes_ber_ctrl_chk.sv ====
// concurrent checks on the bus and control outputs of the bit-error block
`timescale 1ns/100ps
module serdes_ber_ctrl_chk import serdes_ber_pkg::*; #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // control outputs
    input wire logic [2:0] recovery_loop_setting,
    input wire logic offset_cal_enable,
    input wire logic signal_loss_detect_enable,
    input wire logic bit_error_test_enable,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr(logic [9:0] idx);
        awvalid && awready && wvalid && wready && awaddr[11:2] == idx && wstrb[0];
    endsequence
    sequence s_tally_rd;
        arvalid && arready && araddr[11:6] == IDX_LANE_ERROR_TALLY[9:4];
    endsequence
    property p_en_wr;
        logic v;
        (s_wr(IDX_ERROR_TEST_CONTROL), v = wdata[0]) |-> ##2 bit_error_test_enable == v;
    endproperty
    property p_phy_wr;
        logic [6:0] v;
        (s_wr(IDX_SERDES_PHY_CONTROL), v = wdata[6:0]) |-> ##2 recovery_loop_setting == v[6:4]
            && offset_cal_enable == v[1] && signal_loss_detect_enable == v[0];
    endproperty
    property p_dead_slot;
        logic [3:0] n;
        (s_tally_rd, n = araddr[5:2]) |=> rvalid
            && (n == LANE_PHYS[0] || n == LANE_PHYS[1] || rdata == 32'h0000_0000);
    endproperty
    a_phy_reset: assert property (disable iff (1'b0) !aresetn |=>
        recovery_loop_setting == 3'h4 && offset_cal_enable && signal_loss_detect_enable)
        else $error("phy control outputs wrong after reset");
    a_enable_reset: assert property (disable iff (1'b0) !aresetn |=>
        !bit_error_test_enable && !irq) else $error("test enable or irq set after reset");
    a_enable_write: assert property (p_en_wr)
        else $error("test enable does not follow written bit");
    a_phy_write: assert property (p_phy_wr)
        else $error("phy control outputs do not follow write");
    a_idle_tally_zero: assert property ((s_tally_rd and (!bit_error_test_enable
        && $stable(bit_error_test_enable))) |=> rdata == 32'h0000_0000)
        else $error("tally nonzero while test disabled");
    a_dead_slot_zero: assert property (p_dead_slot)
        else $error("disconnected lane tally nonzero");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
        else $error("write response timing wrong");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
endmodule
bind serdes_ber_ctrl serdes_ber_ctrl_chk #(.ADDR_W(ADDR_W)) chk_i (.aclk, .aresetn, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .recovery_loop_setting, .offset_cal_enable,
    .signal_loss_detect_enable, .bit_error_test_enable, .irq);

// ==== verif/tb.sv ====
// self-checking bench for the lane bit-error test and phy control block
`timescale 1ns/100ps
module tb;
    import serdes_ber_pkg::*;
    localparam logic [11:0] A_TC = {IDX_ERROR_TEST_CONTROL, 2'b00};
    localparam logic [11:0] A_PHY = {IDX_SERDES_PHY_CONTROL, 2'b00};
    localparam logic [11:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [1:0] bresp, rresp, lane_rx_bit, lane_rx_valid;
    logic awready, wready, bvalid, arready, rvalid, irq, bit_error_test_enable;
    logic offset_cal_enable, signal_loss_detect_enable;
    logic [2:0] recovery_loop_setting;
    logic [1:0] run = 2'h0, slow = 2'h0, flip = 2'h0, inj = 2'h0;
    logic [3:0] exp_st = 4'h0;
    logic [7:0] v;
    logic hist [2][$];
    int exp_cnt [2] = '{0, 0};
    int fail_count = 0, total_checks = 0, seed = 32'h0000_899c;
    wire [4:0] phy_o = {recovery_loop_setting, offset_cal_enable, signal_loss_detect_enable};
    always #25 aclk = !aclk;
    serdes_ber_ctrl dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
        .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .lane_rx_bit, .lane_rx_valid,
        .recovery_loop_setting, .offset_cal_enable, .signal_loss_detect_enable,
        .bit_error_test_enable, .irq);
    prbs_tx_model far_end (.clk(aclk), .rst_n(aresetn), .run, .slow, .flip,
        .tx_bit(lane_rx_bit), .tx_valid(lane_rx_valid));
    always @(posedge aclk) flip <= inj & 2'($random(seed));
    // reference checker: seven valid bits fill the history, later bits are predicted from it
    always @(posedge aclk) begin
        for (int g = 0; g < 2; g++) begin
            if (!bit_error_test_enable) begin
                exp_cnt[g] = 0;
                hist[g].delete();
            end else if (lane_rx_valid[g]) begin
                if (hist[g].size() == 7) begin
                    if (lane_rx_bit[g] !== (hist[g][6] ^ hist[g][5])) begin
                        exp_st[g] = 1'b1;
                        if (exp_cnt[g] < 255) exp_cnt[g]++;
                        if (exp_cnt[g] == 255) exp_st[g + 2] = 1'b1;
                    end
                    void'(hist[g].pop_back());
                end
                hist[g].push_front(lane_rx_bit[g]);
            end
        end
    end
    function automatic logic [11:0] ta(input int n);
        return {IDX_LANE_ERROR_TALLY + 10'(n), 2'b00};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (50) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                done = 1'b1;
                bready <= 1'b0;
                break;
            end
        end
        chk({done, bresp}, {1'b1, er});
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        repeat (50) begin
            @(posedge aclk);
            if (rvalid && rready) begin
                done = 1'b1;
                rready <= 1'b0;
                break;
            end
            // ready comes a cycle late so the slave must hold its answer
            if (arvalid && arready) arvalid <= 1'b0;
            else if (!arvalid) rready <= 1'b1;
        end
        chk({done, rresp, rdata}, {1'b1, er, 24'h00_0000, e});
    endtask
    task automatic traffic(input logic [1:0] i, input logic [1:0] s, input int n);
        @(posedge aclk);
        run <= 2'h3;
        slow <= s;
        inj <= i;
        repeat (n) @(posedge aclk);
        run <= 2'h0;
        inj <= 2'h0;
        repeat (4) @(posedge aclk);
    endtask
    task automatic tallies;
        rc(ta(6), 8'(exp_cnt[0]), RESP_OKAY);
        rc(ta(14), 8'(exp_cnt[1]), RESP_OKAY);
        rc(ta(3), 8'h00, RESP_OKAY);
        rc(A_ST, {4'h0, exp_st}, RESP_OKAY);
    endtask
    task automatic ic(input logic [3:0] m);
        wr(A_MSK, {4'h0, m}, RESP_OKAY);
        @(negedge aclk);
        chk(irq, |(exp_st & m));
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A_TC, 8'h00, RESP_OKAY);
        rc(A_PHY, 8'h43, RESP_OKAY);
        rc(A_MSK, 8'h00, RESP_OKAY);
        chk(phy_o, 5'h13);
        for (int s = 0; s < 8; s++) begin
            v = 8'($random(seed));
            v[6:4] = 3'(s);
            wr(A_PHY, v, RESP_OKAY);
            rc(A_PHY, v, RESP_OKAY);
            chk(phy_o, {v[6:4], v[1:0]});
        end
        wr(12'h7fc, 8'h5a, RESP_SLVERR);
        rc(12'h7fc, 8'h00, RESP_SLVERR);
        wr(ta(6), 8'h5a, RESP_OKAY);
        $display("test registers done");
        traffic(2'h3, 2'h0, 100);
        tallies();
        wr(A_TC, 8'h01, RESP_OKAY);
        traffic(2'h3, 2'h2, 40);
        traffic(2'h0, 2'h2, 200);
        tallies();
        ic(4'h0);
        ic(4'h4);
        ic(4'hf);
        wr(A_ST, 8'h0f, RESP_OKAY);
        exp_st = 4'h0;
        ic(4'hf);
        $display("test lock_and_irq done");
        traffic(2'h1, 2'h0, 1500);
        rc(ta(6), 8'hff, RESP_OKAY);
        tallies();
        ic(4'h4);
        wr(A_TC, 8'h00, RESP_OKAY);
        wr(A_TC, 8'h01, RESP_OKAY);
        tallies();
        $display("test saturate_restart done");
        report_and_stop();
    end
endmodule
